// *** core/rppk_packer.sv ***
`include "rppk_map.svh"
`default_nettype none
module rppk_packer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire rppk_pkg::rppk_pix_t pix_in,
    output logic out_valid,
    input wire logic out_ready,
    output rppk_pkg::rppk_byte_t out_byte,
    output logic pair_err
);
    import rppk_pkg::*;

    logic rst_meta_q;
    logic rst_n_q;
    rppk_state_t state_q;
    logic [`RPPK_PIX_W-1:0] early_q;
    logic [`RPPK_PIX_W-1:0] late_q;
    logic late_eol_q;
    logic line_odd_q;
    logic pair_odd_q;
    logic pair_err_q;
    logic pix_odd;
    logic push_valid;
    logic push_ready;
    logic push_fire;
    logic pix_fire;
    rppk_byte_t push_data;
    rppk_colour_t early_colour;
    rppk_colour_t late_colour;
    rppk_byte_t buf_out;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Line parity of the incoming pixel, a frame start forces even
    assign pix_odd = pix_in.sof ? `RPPK_RESET_ODD : line_odd_q;

    // Colour of the pixels in each half of a pair
    always_comb begin
        early_colour = COL_BLUE;
        late_colour = COL_GREEN;
        if ((state_q == ST_EARLY) ? pix_odd : pair_odd_q) begin
            early_colour = COL_GREEN;
            late_colour = COL_RED;
        end
    end

    // Byte assembly for each position within the group
    always_comb begin
        push_valid = 1'b0;
        pix_ready = 1'b0;
        push_data = '0;
        case (state_q)
            ST_EARLY: begin
                pix_ready = push_ready;
                push_valid = pix_valid;
                push_data.data = pix_in.value[`RPPK_HI_MSB:`RPPK_HI_LSB];
                push_data.kind = KIND_HI_EARLY;
                push_data.colour = early_colour;
                push_data.odd_line = pix_odd;
                push_data.sol = pix_in.sol;
            end
            ST_LATE: begin
                pix_ready = push_ready;
                push_valid = pix_valid;
                push_data.data[`RPPK_MID_LATE_LSB+:4] =
                    pix_in.value[`RPPK_LO_MSB:`RPPK_LO_LSB];
                push_data.data[`RPPK_MID_EARLY_LSB+:4] =
                    early_q[`RPPK_LO_MSB:`RPPK_LO_LSB];
                push_data.kind = KIND_MID;
                push_data.colour = early_colour;
                push_data.odd_line = pair_odd_q;
            end
            ST_TAIL: begin
                push_valid = 1'b1;
                push_data.data = late_q[`RPPK_HI_MSB:`RPPK_HI_LSB];
                push_data.kind = KIND_HI_LATE;
                push_data.colour = late_colour;
                push_data.odd_line = pair_odd_q;
                push_data.eol = late_eol_q;
            end
            default: begin
                push_valid = 1'b0;
            end
        endcase
    end

    assign push_fire = push_valid && push_ready;
    assign pix_fire = pix_valid && pix_ready;

    // Two pixels in, three bytes out
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_EARLY;
        end else if (push_fire) begin
            case (state_q)
                ST_EARLY: state_q <= ST_LATE;
                ST_LATE: state_q <= ST_TAIL;
                ST_TAIL: state_q <= ST_EARLY;
                default: state_q <= ST_EARLY;
            endcase
        end
    end

    // Full twelve-bit samples kept as received
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            early_q <= '0;
            late_q <= '0;
            late_eol_q <= 1'b0;
        end else if (pix_fire && state_q == ST_EARLY) begin
            early_q <= pix_in.value;
        end else if (pix_fire && state_q == ST_LATE) begin
            late_q <= pix_in.value;
            late_eol_q <= pix_in.eol;
        end
    end

    // Line parity, flips after the last group of each line
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            line_odd_q <= `RPPK_RESET_ODD;
            pair_odd_q <= `RPPK_RESET_ODD;
        end else if (pix_fire && state_q == ST_EARLY) begin
            line_odd_q <= pix_odd;
            pair_odd_q <= pix_odd;
        end else if (push_fire && state_q == ST_TAIL && late_eol_q) begin
            line_odd_q <= ~pair_odd_q;
        end
    end

    // Flags a line marker that falls inside a pair
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pair_err_q <= 1'b0;
        end else begin
            pair_err_q <= pix_fire && ((state_q == ST_EARLY && pix_in.eol)
                || (state_q == ST_LATE && (pix_in.sol || pix_in.sof)));
        end
    end

    assign pair_err = pair_err_q;

    rppk_buf #(
        .W($bits(rppk_byte_t)),
        .DEPTH(`RPPK_BUF_DEPTH)
    ) u_buf (
        .clk(core_clk),
        .rst_n(rst_n_q),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_out)
    );

    assign out_byte = buf_out;

    // Checking helpers
    logic out_fire;
    logic [`RPPK_PIX_W-1:0] chk_early_q;
    logic [`RPPK_PIX_W-1:0] chk_late_q;
    rppk_kind_t chk_last_kind_q;
    logic chk_last_odd_q;

    assign out_fire = out_valid && out_ready;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chk_early_q <= '0;
            chk_late_q <= '0;
        end else if (pix_valid && pix_ready) begin
            if (state_q == ST_EARLY) begin
                chk_early_q <= pix_in.value;
            end else begin
                chk_late_q <= pix_in.value;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chk_last_kind_q <= KIND_HI_LATE;
            chk_last_odd_q <= 1'b0;
        end else if (out_fire) begin
            chk_last_kind_q <= out_byte.kind;
            chk_last_odd_q <= out_byte.odd_line;
        end
    end

    AST_EARLY_HI: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.kind == KIND_HI_EARLY
            |-> out_byte.data == chk_early_q[11:4])
        else $error("first byte of group lost upper bits of earlier pixel");

    AST_MID_SHARE: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.kind == KIND_MID
            |-> out_byte.data[3:0] == chk_early_q[3:0]
                && out_byte.data[7:4] == chk_late_q[3:0])
        else $error("shared byte does not carry both low nibbles");

    AST_NIBBLE_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.kind == KIND_MID && chk_early_q[3:0] != chk_late_q[3:0]
            |-> out_byte.data[7:4] != chk_early_q[3:0])
        else $error("earlier nibble placed in upper half of shared byte");

    AST_LATE_HI: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.kind == KIND_HI_LATE
            |-> out_byte.data == chk_late_q[11:4])
        else $error("third byte of group lost upper bits of later pixel");

    AST_GROUP_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire |-> (out_byte.kind == KIND_HI_EARLY && chk_last_kind_q == KIND_HI_LATE)
            || (out_byte.kind == KIND_MID && chk_last_kind_q == KIND_HI_EARLY)
            || (out_byte.kind == KIND_HI_LATE && chk_last_kind_q == KIND_MID))
        else $error("byte group out of order");

    AST_EVEN_COLOUR: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && !out_byte.odd_line
            |-> out_byte.colour == ((out_byte.kind == KIND_HI_LATE) ? COL_GREEN : COL_BLUE))
        else $error("even line colour sequence wrong");

    AST_ODD_COLOUR: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.odd_line
            |-> out_byte.colour == ((out_byte.kind == KIND_HI_LATE) ? COL_RED : COL_GREEN))
        else $error("odd line colour sequence wrong");

    AST_LINE_START: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        pix_fire && pix_in.sol
            |-> (state_q == ST_EARLY ##1 state_q == ST_LATE) or (##1 pair_err))
        else $error("line start not aligned to a new group");

    AST_LINE_END: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.eol |-> out_byte.kind == KIND_HI_LATE)
        else $error("line ended inside a group");

    AST_TAIL_NO_TAKE: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        state_q == ST_TAIL |-> !pix_ready)
        else $error("pixel taken while third byte pending");

    AST_PARITY_FLIP: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        push_fire && state_q == ST_TAIL && late_eol_q |=> line_odd_q != $past(pair_odd_q))
        else $error("line parity did not alternate");

    AST_STALL_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_valid && !out_ready |=> out_valid && $stable(out_byte))
        else $error("output byte changed under stall");

    AST_SOL_SLOT: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        pix_fire && (pix_in.sol || pix_in.sof) && state_q == ST_LATE |=> pair_err)
        else $error("line start on a later pixel not flagged");

    AST_EOL_SLOT: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        pix_fire && pix_in.eol && state_q == ST_EARLY |=> pair_err)
        else $error("line end on an earlier pixel not flagged");

    AST_SOL_TAG: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.sol |-> out_byte.kind == KIND_HI_EARLY)
        else $error("line start tag not on first byte of group");

    AST_FRAME_EVEN: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        pix_fire && pix_in.sof && state_q == ST_EARLY |=> !pair_odd_q)
        else $error("frame start did not select an even line");

    AST_GROUP_LINE: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.kind != KIND_HI_EARLY
            |-> out_byte.odd_line == chk_last_odd_q)
        else $error("line parity changed inside a group");

    AST_FULL_STALL: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        !push_ready |-> !pix_ready)
        else $error("pixel offered a slot while buffer full");

    AST_EARLY_TAKE: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        pix_fire && state_q == ST_EARLY |=> state_q == ST_LATE)
        else $error("earlier pixel did not advance to later slot");

    COV_ODD_GROUP: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.odd_line && out_byte.kind == KIND_HI_LATE);

    COV_LINE_END: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.eol ##1 out_fire && out_byte.sol);

    COV_STALL_FULL: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        push_valid && !push_ready);

    COV_PAIR_ERR: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        pair_err);

    COV_ODD_LINE_END: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        out_fire && out_byte.eol && out_byte.odd_line);
endmodule
`default_nettype wire

// *** core/rppk_map.svh ***
`ifndef RPPK_MAP_SVH
`define RPPK_MAP_SVH

`define RPPK_PIX_W 12
`define RPPK_BYTE_W 8
`define RPPK_PIX_MAX 12'hfff
`define RPPK_HI_MSB 11
`define RPPK_HI_LSB 4
`define RPPK_LO_MSB 3
`define RPPK_LO_LSB 0
`define RPPK_MID_EARLY_LSB 0
`define RPPK_MID_LATE_LSB 4
`define RPPK_BYTES_PER_PAIR 3
`define RPPK_PIX_PER_PAIR 2
`define RPPK_BUF_DEPTH 2
`define RPPK_RESET_ODD 1'b0

`endif

// *** core/rppk_pkg.sv ***
`include "rppk_map.svh"
`default_nettype none
package rppk_pkg;

    typedef enum logic [1:0] {
        COL_BLUE,
        COL_GREEN,
        COL_RED
    } rppk_colour_t;

    typedef enum logic [1:0] {
        KIND_HI_EARLY,
        KIND_MID,
        KIND_HI_LATE
    } rppk_kind_t;

    typedef enum logic [1:0] {
        ST_EARLY,
        ST_LATE,
        ST_TAIL
    } rppk_state_t;

    // One sensor sample with its frame and line markers
    typedef struct packed {
        logic [`RPPK_PIX_W-1:0] value;
        logic sof;
        logic sol;
        logic eol;
    } rppk_pix_t;

    // One packed output byte with its position tags
    typedef struct packed {
        logic [`RPPK_BYTE_W-1:0] data;
        rppk_kind_t kind;
        rppk_colour_t colour;
        logic odd_line;
        logic sol;
        logic eol;
    } rppk_byte_t;

endpackage
`default_nettype wire

// *** core/rppk_buf.sv ***
`default_nettype none
module rppk_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign in_ready = rst_n && (count_q != FULL_CNT);
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** tb/rppk_host_model.sv ***
`default_nettype none
module rppk_host_model (
    input wire logic core_clk,
    input wire logic [1:0] mode,
    input wire logic out_valid,
    input wire rppk_pkg::rppk_byte_t out_byte,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    import rppk_pkg::*;
    rppk_byte_t got[$];
    int tick = 0;
    // Stores a byte on valid and ready, then sets ready for the next edge
    always @(posedge core_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back(out_byte);
        end
        tick++;
        #1;
        out_ready = (mode == 2'd0) || (mode == 2'd1 && tick % 3 == 0);
    end
endmodule
`default_nettype wire

// *** tb/rppk_tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rppk_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic pix_valid = 1'b0;
    rppk_pix_t pix_in = '0;
    logic pix_ready, out_valid, out_ready, pair_err, tk;
    rppk_byte_t out_byte;
    logic [1:0] hmode = 2'd0;
    logic odd = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    int errs = 0;
    int cyc = 0;
    rppk_byte_t exq[$];

    always #2.5 core_clk = ~core_clk;

    rppk_packer dut (.core_clk(core_clk), .nrst(nrst), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_in(pix_in), .out_valid(out_valid),
        .out_ready(out_ready), .out_byte(out_byte), .pair_err(pair_err));
    rppk_host_model host (.core_clk(core_clk), .mode(hmode), .out_valid(out_valid),
        .out_byte(out_byte), .out_ready(out_ready));

    always @(posedge core_clk) begin
        cyc++;
        if (pair_err === 1'b1) errs++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] expd);
        num_checks++;
        if (seen !== expd) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, expd, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Three expected bytes of one pair, colour from the line parity
    task automatic push_pair(logic [11:0] e, logic [11:0] l, logic first, logic last);
        rppk_colour_t ce, cl;
        ce = odd ? COL_GREEN : COL_BLUE;
        cl = odd ? COL_RED : COL_GREEN;
        exq.push_back('{e[11:4], KIND_HI_EARLY, ce, odd, first, 1'b0});
        exq.push_back('{{l[3:0], e[3:0]}, KIND_MID, ce, odd, 1'b0, 1'b0});
        exq.push_back('{l[11:4], KIND_HI_LATE, cl, odd, 1'b0, last});
    endtask

    // Offers one pixel, markers m = {sof, sol, eol}; tk tells if it was taken
    task automatic send_px(logic [11:0] v, logic [2:0] m, int lim);
        tk = 1'b0;
        pix_valid = 1'b1;
        pix_in = '{v, m[2], m[1], m[0]};
        for (int n = 0; n < lim && !tk; n++) begin
            @(negedge core_clk);
            tk = (pix_ready === 1'b1);
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic send_line(int n, logic [11:0] base, logic [11:0] step, logic sof);
        logic [11:0] v, e;
        if (sof) odd = 1'b0;
        for (int i = 0; i < n; i++) begin
            v = base + 12'(i) * step;
            send_px(v, {sof && i == 0, i == 0, i == n - 1}, 50);
            check("pixel taken", 16'(tk), 16'h1);
            if (i % 2 == 1) push_pair(e, v, i == 1, i == n - 1);
            e = v;
        end
        pix_valid = 1'b0;
        odd = ~odd;
        @(posedge core_clk);
        #1;
    endtask

    // Waits for the host to hold all expected bytes, checks the count, then compares the bytes only when cmp is set
    task automatic drain(logic cmp);
        int k;
        k = 0;
        while (host.got.size() < exq.size() && k < 200) begin
            @(posedge core_clk);
            k++;
        end
        repeat (4) @(posedge core_clk);
        #1;
        check("byte count", 16'(host.got.size()), 16'(exq.size()));
        for (int j = 0; j < exq.size() && cmp; j++) begin
            check("byte", 16'(host.got[j]), 16'(exq[j]));
        end
        host.got.delete();
        exq.delete();
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check("outputs in reset", 16'({pix_ready, out_valid}), 16'h0);
        nrst = 1'b1;
        odd = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic t_lines();
        hmode = 2'd0;
        send_line(4, 12'h000, 12'hfff, 1'b1);
        send_line(6, 12'h5a3, 12'h7b1, 1'b0);
        send_line(2, 12'h9c6, 12'h111, 1'b0);
        drain(1'b1);
        check("error pulses", 16'(errs), 16'h0);
    endtask

    task automatic t_stall();
        hmode = 2'd1;
        send_line(8, 12'h0f0, 12'h3e5, 1'b1);
        drain(1'b1);
    endtask

    task automatic t_full();
        hmode = 2'd2;
        odd = 1'b0;
        send_px(12'h123, 3'b110, 50);
        send_px(12'h456, 3'b000, 50);
        send_px(12'h789, 3'b000, 8);
        check("taken while full", 16'(tk), 16'h0);
        hmode = 2'd0;
        send_px(12'h789, 3'b000, 50);
        send_px(12'habc, 3'b001, 50);
        pix_valid = 1'b0;
        push_pair(12'h123, 12'h456, 1'b1, 1'b0);
        push_pair(12'h789, 12'habc, 1'b0, 1'b1);
        odd = 1'b1;
        drain(1'b1);
    endtask

    // Line end on an earlier pixel, then line start on a later one
    task automatic t_err();
        int e0;
        e0 = errs;
        send_px(12'h321, 3'b111, 50);
        send_px(12'h654, 3'b001, 50);
        send_px(12'h987, 3'b010, 50);
        send_px(12'hcba, 3'b011, 50);
        pix_valid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("error pulses", 16'(errs - e0), 16'h2);
        push_pair(12'h000, 12'h000, 1'b0, 1'b0);
        push_pair(12'h000, 12'h000, 1'b0, 1'b0);
        drain(1'b0);
    endtask

    // A reset in mid-run brings the line parity back to even
    task automatic t_reset();
        send_line(2, 12'h0aa, 12'h101, 1'b1);
        drain(1'b1);
        do_reset();
        send_line(2, 12'h777, 12'h011, 1'b0);
        drain(1'b1);
    endtask

    initial begin
        do_reset();
        t_lines();
        t_stall();
        t_full();
        t_err();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
